//--- core/mv_remap.sv
// motion vector remap stage: macroblock vectors into thread payload slots
`timescale 1ns/1ps
`default_nettype none
module mv_remap
  import mv_remap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inValid,
  output logic inReady,
  input wire mb_in_t mbIn,
  output logic outValid,
  input wire logic outReady,
  output payload_t payload
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] dpComp(input logic signed [15:0] v,
                                                 input logic signed [15:0] m,
                                                 input logic signed [15:0] e,
                                                 input logic signed [1:0] d);
    logic signed [17:0] vx;
    logic signed [17:0] prod;
    vx = 18'(v);
    prod = vx * 18'(m);
    prod = prod + ((v > 16'sh0000) ? 18'sh00001 : 18'sh00000);
    prod = prod >>> 1;
    dpComp = 16'(prod + 18'(e) + 18'(d));
  endfunction

  function automatic mv_t dpVec(input mv_t v, input logic signed [15:0] m,
                                input logic signed [15:0] e,
                                input logic signed [1:0] dh, input logic signed [1:0] dv);
    mv_t r;
    r.h = dpComp(v.h, m, DP_E_ZERO, dh);
    r.v = dpComp(v.v, m, e, dv);
    dpVec = r;
  endfunction

  function automatic logic regHit(input logic [31:0] a, input logic [11:0] off);
    // only the low offset bits decode, so the map aliases upward
    regHit = (a[11:0] == off);
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic enable_q, enable_d;
  logic dpErr_q, dpErr_d;
  logic [31:0] mbCount_q, mbCount_d;
  logic [31:0] dpCount_q, dpCount_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic inReady_q, inReady_d;
  logic outValid_q, outValid_d;
  payload_t payload_q, payload_d;

  logic accept;
  logic apbWrite;
  logic apbSetup;
  logic mapped;
  logic [31:0] readVal;
  payload_t mapped_pl;
  logic isDual;

  assign accept = inValid && inReady_q;
  assign apbSetup = psel && penable && !pready_q;
  assign apbWrite = psel && penable && pready_q && pwrite;

  // ----------------------------------------------------------------
  // vector mapping
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] mt;
    logic isFrame;
    logic isBot;
    logic [2:0] k;
    mt = 2'h0;
    isFrame = 1'b0;
    isBot = 1'b0;
    k = 3'h0;
    mapped_pl = '0;
    isDual = 1'b0;
    isFrame = (mbIn.picStruct == PS_FRAME);
    isBot = (mbIn.picStruct == PS_BOT);
    mt = mbIn.motionTypePresent ? mbIn.motionType : (isFrame ? MT_FRAME : MT_FIELD);
    if (mbIn.intra) begin
      // vector kept for concealment only, no reference attached
      if (mbIn.concealment) begin
        mapped_pl.mv[0] = mbIn.mv[0];
      end
    end else if (mbIn.codingType == PC_P && !mbIn.forward && !mbIn.backward) begin
      mapped_pl.predict = 1'b1;
      mapped_pl.refSel[0] = REF_FIRST;
      mapped_pl.vsel[0] = isBot;
    end else if (mt == MT_DUAL) begin
      if (mbIn.codingType != PC_P || !mbIn.forward) begin
        // dual prime outside a P picture is dropped and flagged
        mapped_pl.dpError = 1'b1;
      end else begin
        isDual = 1'b1;
        mapped_pl.predict = 1'b1;
        mapped_pl.mv[0] = mbIn.mv[0];
        mapped_pl.refSel[0] = REF_FIRST;
        mapped_pl.refSel[1] = REF_SECOND;
        if (isFrame) begin
          mapped_pl.mv[2] = mbIn.mv[0];
          mapped_pl.mv[1] = dpVec(mbIn.mv[0], DP_M_NEAR, DP_E_UP, mbIn.dmvH, mbIn.dmvV);
          mapped_pl.mv[3] = dpVec(mbIn.mv[0], DP_M_FAR, DP_E_DOWN, mbIn.dmvH, mbIn.dmvV);
          mapped_pl.refSel[2] = REF_FIRST;
          mapped_pl.refSel[3] = REF_SECOND;
          mapped_pl.vsel = VSEL_FRAME_DUAL;
        end else begin
          mapped_pl.mv[1] = dpVec(mbIn.mv[0], DP_M_NEAR, isBot ? DP_E_DOWN : DP_E_UP,
                                  mbIn.dmvH, mbIn.dmvV);
          mapped_pl.vsel[0] = isBot;
          mapped_pl.vsel[1] = !isBot;
        end
      end
    end else begin
      mapped_pl.predict = 1'b1;
      // two vectors per direction for field in frame and for 16x8
      if ((isFrame && mt == MT_FIELD) || (!isFrame && mt == MT_16X8)) begin
        if (mbIn.forward) begin
          mapped_pl.mv[0] = mbIn.mv[k];
          mapped_pl.mv[2] = mbIn.mv[k + 3'h1];
          mapped_pl.refSel[0] = REF_FIRST;
          mapped_pl.refSel[2] = REF_FIRST;
          mapped_pl.vsel[0] = mbIn.vselIn[0];
          mapped_pl.vsel[2] = mbIn.vselIn[2];
          k = k + 3'h2;
        end
        if (mbIn.backward) begin
          mapped_pl.mv[1] = mbIn.mv[k];
          mapped_pl.mv[3] = mbIn.mv[k + 3'h1];
          mapped_pl.refSel[1] = REF_SECOND;
          mapped_pl.refSel[3] = REF_SECOND;
          mapped_pl.vsel[1] = mbIn.vselIn[1];
          mapped_pl.vsel[3] = mbIn.vselIn[3];
        end
      end else begin
        if (mbIn.forward) begin
          mapped_pl.mv[0] = mbIn.mv[k];
          mapped_pl.refSel[0] = REF_FIRST;
          mapped_pl.vsel[0] = mbIn.vselIn[0];
          k = k + 3'h1;
        end
        if (mbIn.backward) begin
          mapped_pl.mv[1] = mbIn.mv[k];
          mapped_pl.refSel[1] = REF_SECOND;
          mapped_pl.vsel[1] = mbIn.vselIn[1];
        end
      end
    end
    // second field of a field picture may point at its own first field
    if (!isFrame && mbIn.secondField && mbIn.codingType == PC_P) begin
      if (mapped_pl.refSel[0] != REF_NONE && mapped_pl.vsel[0] != isBot) begin
        mapped_pl.refSel[0] = REF_DEST;
      end
      if (mapped_pl.refSel[1] != REF_NONE && mapped_pl.vsel[1] != isBot) begin
        mapped_pl.refSel[1] = REF_DEST;
      end
      if (mapped_pl.refSel[2] != REF_NONE && mapped_pl.vsel[2] != isBot) begin
        mapped_pl.refSel[2] = REF_DEST;
      end
    end
  end

  // ----------------------------------------------------------------
  // stream handshake
  // ----------------------------------------------------------------
  always_comb begin
    payload_d = payload_q;
    outValid_d = outValid_q && !outReady;
    if (accept) begin
      payload_d = mapped_pl;
      outValid_d = 1'b1;
    end
    // ready is registered, so a beat only enters an empty stage
    inReady_d = enable_q && !outValid_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      inReady_q <= 1'b0;
      outValid_q <= 1'b0;
      payload_q <= '0;
    end else begin
      inReady_q <= inReady_d;
      outValid_q <= outValid_d;
      payload_q <= payload_d;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    readVal = 32'h0000_0000;
    if (regHit(paddr, REG_CTRL)) begin
      readVal[CTRL_EN_BIT] = enable_q;
    end else if (regHit(paddr, REG_STATUS)) begin
      readVal[ST_ERR_BIT] = dpErr_q;
      readVal[ST_OUTV_BIT] = outValid_q;
    end else if (regHit(paddr, REG_MB_COUNT)) begin
      readVal = mbCount_q;
    end else if (regHit(paddr, REG_DP_COUNT)) begin
      readVal = dpCount_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // one wait state keeps the read mux off the pready path
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    pready_d = apbSetup;
    if (apbSetup) begin
      prdata_d = pwrite ? 32'h0000_0000 : readVal;
      pslverr_d = !mapped;
    end else begin
      pslverr_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // control and counters
  // ----------------------------------------------------------------
  always_comb begin
    enable_d = enable_q;
    dpErr_d = dpErr_q;
    mbCount_d = mbCount_q;
    dpCount_d = dpCount_q;
    if (apbWrite && mapped && regHit(paddr, REG_CTRL)) begin
      enable_d = pwdata[CTRL_EN_BIT];
    end
    if (apbWrite && mapped && regHit(paddr, REG_STATUS) && pwdata[ST_ERR_BIT]) begin
      dpErr_d = 1'b0;
    end
    // a new error in the clearing cycle stays set
    if (accept && mapped_pl.dpError) begin
      dpErr_d = 1'b1;
    end
    // counters wrap silently, software works with differences
    if (accept) begin
      mbCount_d = mbCount_q + 32'h0000_0001;
    end
    if (accept && isDual) begin
      dpCount_d = dpCount_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_q <= CTRL_EN_RESET;
      dpErr_q <= 1'b0;
      mbCount_q <= 32'h0000_0000;
      dpCount_q <= 32'h0000_0000;
    end else begin
      enable_q <= enable_d;
      dpErr_q <= dpErr_d;
      mbCount_q <= mbCount_d;
      dpCount_q <= dpCount_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign payload = payload_q;

endmodule
`default_nettype wire

//--- dv/mv_remap_sva.sv
// checker for the motion vector remap stage
`timescale 1ns/1ps
`default_nettype none
module mv_remap_sva
  import mv_remap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pready,
  input wire logic inValid,
  input wire logic inReady,
  input wire mb_in_t mbIn,
  input wire logic outValid,
  input wire logic outReady,
  input wire payload_t payload
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // -------------------------
  // helpers
  // -------------------------
  logic take, dual, pDual;
  assign take = inValid && inReady;
  assign dual = mbIn.motionTypePresent && mbIn.motionType == MT_DUAL && !mbIn.intra;
  assign pDual = take && dual && mbIn.codingType == PC_P && mbIn.forward;
  apb_pulse_a: assert property (pready |=> !pready) else $error("pready stuck high");
  dp_nonp_a: assert property (take && dual && mbIn.codingType != PC_P |=> payload.dpError && !payload.predict) else $error("dual prime outside P accepted");
  frame_sel_a: assert property (pDual && mbIn.picStruct == PS_FRAME |=> payload.vsel == VSEL_FRAME_DUAL) else $error("frame dual select wrong");
  frame_slots_a: assert property (pDual && mbIn.picStruct == PS_FRAME |=> payload.mv[0] == $past(mbIn.mv[0]) && payload.mv[2] == $past(mbIn.mv[0])) else $error("frame dual same parity slots wrong");
  field_sel_a: assert property (pDual && mbIn.picStruct != PS_FRAME |=> payload.vsel[0] == $past(mbIn.picStruct == PS_BOT) && payload.vsel[1] != payload.vsel[0]) else $error("field dual select wrong");
  intra_pred_a: assert property (take && mbIn.intra |=> !payload.predict && payload.refSel == '0) else $error("intra formed a prediction");
  skip_zero_a: assert property (take && !mbIn.intra && !dual && mbIn.codingType == PC_P && !mbIn.forward && !mbIn.backward |=> payload.mv[0] == '0 && payload.refSel[0] == REF_FIRST) else $error("skipped P vector not zero");
  back_slot_a: assert property (outValid && payload.predict && payload.refSel[3] != REF_NONE |-> payload.refSel[3] == REF_SECOND) else $error("slot three not backward");
  fwd_slot_a: assert property (outValid && payload.predict |-> payload.refSel[2] != REF_SECOND) else $error("slot two references backward");
  out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(payload)) else $error("payload dropped before accept");
  cover property (pDual && mbIn.picStruct == PS_FRAME);
  cover property (pDual && mbIn.picStruct == PS_BOT);
  cover property (outValid && payload.dpError);
endmodule
bind mv_remap mv_remap_sva mv_remap_sva_i (.clk(clk), .rst_b(rst_b), .pready(pready),
  .inValid(inValid), .inReady(inReady), .mbIn(mbIn), .outValid(outValid),
  .outReady(outReady), .payload(payload));
`default_nettype wire

//--- dv/mv_sink.sv
// downstream thread dispatch model: accepts payloads promptly or after a stall
`timescale 1ns/1ps
`default_nettype none
module mv_sink (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic outValid,
  input wire logic slow,
  output logic outReady
);
  logic [1:0] waitQ;
  // slow mode stalls each payload three cycles
  assign outReady = !slow || waitQ == 2'h3;
  always_ff @(posedge clk) begin
    if (!rst_b || !outValid || outReady) begin
      waitQ <= 2'h0;
    end else begin
      waitQ <= waitQ + 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking testbench of the motion vector remap stage
`timescale 1ns/1ps
`default_nettype none
module tb_top import mv_remap_pkg::*;;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, inValid, inReady;
  logic outValid, outReady, slow, e;
  logic [31:0] paddr, pwdata, prdata, r;
  mb_in_t mbIn, mb;
  payload_t payload, got;
  int nErrors, nCompared;
  mv_t a, b, c, d;
  mv_remap mv_remap_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .inValid(inValid), .inReady(inReady), .mbIn(mbIn),
    .outValid(outValid), .outReady(outReady), .payload(payload));
  mv_sink mv_sink_i (.clk(clk), .rst_b(rst_b), .outValid(outValid), .slow(slow),
    .outReady(outReady));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // -------------------------
  // shared tasks
  // -------------------------
  task give_verdict;
    $display("errors=%0d compared=%0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x);
    nCompared++;
    if (g !== x) begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task hang(input int k);
    if (k >= 40) begin
      nErrors++;
      give_verdict();
    end
  endtask
  task apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 40);
    hang(k);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task send(input mb_in_t m);
    int k;
    k = 0;
    mbIn <= m;
    inValid <= 1'b1;
    do begin @(posedge clk); k++; end while (inReady !== 1'b1 && k < 40);
    inValid <= 1'b0;
    do begin @(posedge clk); k++; end while (outValid !== 1'b1 && k < 40);
    hang(k);
    got = payload;
  endtask
  function automatic mv_t mv(input logic [15:0] h, input logic [15:0] v);
    return {h, v};
  endfunction
  function automatic logic [15:0] dc(input int v, input int m, input int x);
    int t;
    t = (v * m + int'(v > 0)) >>> 1;
    return 16'(t + x);
  endfunction
  // flags: present, forward, backward, intra, concealment
  function automatic mb_in_t mk(input logic [1:0] ps, input logic [1:0] ct,
      input logic [1:0] mt, input logic [4:0] f);
    mb_in_t x;
    x = '0;
    {x.picStruct, x.codingType, x.motionType} = {ps, ct, mt};
    {x.motionTypePresent, x.forward, x.backward, x.intra, x.concealment} = f;
    x.mv = {d, c, b, a};
    return x;
  endfunction
  // -------------------------
  // scenarios
  // -------------------------
  task sc_regs;
    apb(1'b0, 32'(REG_CTRL), 32'h0); cmp(r, 32'h1);
    apb(1'b0, 32'h10, 32'h0); cmp(32'(e), 32'h1);
    apb(1'b1, 32'(REG_CTRL), 32'h0);
    @(posedge clk);
    cmp(32'(inReady), 32'h0);
    apb(1'b1, 32'(REG_CTRL), 32'h1);
  endtask
  task sc_dual;
    a = mv(16'h4, 16'h6);
    send(mk(PS_FRAME, PC_P, MT_DUAL, 5'h18));
    cmp(got.mv[0], a); cmp(got.mv[2], a);
    cmp(got.mv[1], mv(dc(4, 1, 0), dc(6, 1, -1)));
    cmp(got.mv[3], mv(dc(4, 3, 0), dc(6, 3, 1)));
    cmp(32'(got.vsel), 32'(VSEL_FRAME_DUAL));
    cmp(32'(got.refSel), 32'h99);
    a = mv(-16'sd5, 16'h3);
    mb = mk(PS_BOT, PC_P, MT_DUAL, 5'h18);
    mb.dmvH = 2'sb01;
    mb.dmvV = 2'sb11;
    send(mb);
    cmp(got.mv[0], a); cmp(got.mv[1], mv(dc(-5, 1, 1), dc(3, 1, 0)));
    cmp(32'(got.vsel[1:0]), 32'h1);
    send(mk(PS_FRAME, 2'h3, MT_DUAL, 5'h18));
    cmp(32'({got.dpError, got.predict}), 32'h2);
    apb(1'b0, 32'(REG_STATUS), 32'h0); cmp(32'(r[ST_ERR_BIT]), 32'h1);
    apb(1'b1, 32'(REG_STATUS), 32'h1);
    apb(1'b0, 32'(REG_STATUS), 32'h0); cmp(32'(r[ST_ERR_BIT]), 32'h0);
    apb(1'b0, 32'(REG_MB_COUNT), 32'h0);
    cmp(r, 32'h3);
    apb(1'b0, 32'(REG_DP_COUNT), 32'h0);
    cmp(r, 32'h2);
  endtask
  task sc_other;
    {a, b, c, d} = {mv(16'h1, 16'h2), mv(16'h3, 16'h4), mv(16'h5, 16'h6), mv(16'h7, 16'h8)};
    send(mk(PS_FRAME, 2'h1, MT_FRAME, 5'h03));
    cmp(got.mv[0], a); cmp(32'(got.predict), 32'h0);
    send(mk(PS_FRAME, PC_P, MT_FRAME, 5'h10));
    cmp(got.mv[0], 32'h0); cmp(32'(got.refSel[0]), 32'(REF_FIRST));
    slow <= 1'b1;
    send(mk(PS_TOP, 2'h3, MT_16X8, 5'h1c));
    cmp(got.mv[0], a); cmp(got.mv[2], b); cmp(got.mv[1], c); cmp(got.mv[3], d);
    send(mk(PS_TOP, 2'h3, MT_FRAME, 5'h0c));
    cmp(got.mv[0], a); cmp(got.mv[1], b);
    mb = mk(PS_TOP, PC_P, MT_DUAL, 5'h18);
    mb.secondField = 1'b1;
    send(mb);
    cmp(32'(got.refSel), 32'h0d);
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, inValid, slow} = '0;
    {paddr, pwdata, a, b, c, d} = '0;
    mbIn = '0;
    nErrors = 0;
    nCompared = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    sc_regs();
    sc_dual();
    sc_other();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- include/mv_remap_pkg.sv
// constants, carriers and register map of the motion vector remap stage
// What this block does
// - dual prime is taken as valid only in a P picture, never in an I or B picture.
// - in dual prime each field gets two predictions, paired like forward and backward, to be averaged.
// - dual prime takes one vector from the stream and derives the companion vector in hardware.
// - every dual prime prediction is rewritten as a forward plus backward field prediction.
// - frame dual prime puts same parity in slots [0][0] and [1][0], derived in [0][1] and [1][1], select 6h.
// - field dual prime puts same parity in [0][0], derived in [0][1], select bit 0 is parity, bit 1 its inverse.
// - an intra macroblock carries a vector only under concealment and forms no prediction from it.
// - an absent motion type means frame based in frame pictures and field based in field pictures.
// - a P macroblock with neither direction flagged gets a zero forward vector.
// - transmitted vectors fill payload slots in stream order.
// - any combined prediction is one forward slot vector paired with one backward slot vector.
// - slot [0][0] references forward, slot [0][1] backward, either of them the destination in a second field.
// - slot [1][0] references forward or destination only, slot [1][1] always the backward picture.
package mv_remap_pkg;
  typedef struct packed {
    logic signed [15:0] h;
    logic signed [15:0] v;
  } mv_t;

  typedef enum logic [1:0] {
    REF_NONE = 2'b00,
    REF_FIRST = 2'b01,
    REF_SECOND = 2'b10,
    REF_DEST = 2'b11
  } ref_t;

  typedef struct packed {
    logic [1:0] picStruct;
    logic [1:0] codingType;
    logic [1:0] motionType;
    logic motionTypePresent;
    logic forward;
    logic backward;
    logic intra;
    logic concealment;
    logic secondField;
    logic [3:0] vselIn;
    mv_t [3:0] mv;
    logic signed [1:0] dmvH;
    logic signed [1:0] dmvV;
  } mb_in_t;

  typedef struct packed {
    mv_t [3:0] mv;
    ref_t [3:0] refSel;
    logic [3:0] vsel;
    logic predict;
    logic dpError;
  } payload_t;

  localparam logic [1:0] PS_TOP = 2'h1;
  localparam logic [1:0] PS_BOT = 2'h2;
  localparam logic [1:0] PS_FRAME = 2'h3;
  localparam logic [1:0] PC_P = 2'h2;
  localparam logic [1:0] MT_FIELD = 2'h1;
  localparam logic [1:0] MT_FRAME = 2'h2;
  localparam logic [1:0] MT_16X8 = 2'h2;
  localparam logic [1:0] MT_DUAL = 2'h3;
  localparam logic [3:0] VSEL_FRAME_DUAL = 4'h6;
  localparam logic signed [15:0] DP_M_NEAR = 16'h0001;
  localparam logic signed [15:0] DP_M_FAR = 16'h0003;
  localparam logic signed [15:0] DP_E_UP = 16'hffff;
  localparam logic signed [15:0] DP_E_DOWN = 16'h0001;
  localparam logic signed [15:0] DP_E_ZERO = 16'h0000;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MB_COUNT = 12'h008;
  localparam logic [11:0] REG_DP_COUNT = 12'h00c;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_OUTV_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;
endpackage
